// ===== logic/pdt_device.sv
`timescale 1ns/1ps
// Behaviour
// - Controller loads sleep length before sleeping
// - Count length down to zero, then run the settle phase, then end
// - Length is 23 bits over three bytes
// - Decrement once per slow crystal period
// - Length fields reset to zero
// - Stay asleep ignores counts until cancelled or card sleep bit clears
// - 24-bit tick counter counts slow periods
// - Tick counter cleared only by reset
// - Tick count read as three bytes
// - Firmware never writes tick count registers
// - Host permit bit gates host memory access
// - Flash wait codes 0,1,2,3 give 0,1,2,3 states
// - Each wait state is two main clocks
// - Firmware sets enough flash wait states
// - Reserved bits written zero, read undefined
// - Sleep command starts cycle, self-clears when done
// - Settle phase is settle time times sixteen
// - Completion sets done flag and interrupt
module pdt_device (
    input wire logic mclk,
    input wire logic resetn,
    pdt_if.device bus,
    input wire logic flash_req,
    output logic flash_ready,
    input wire logic host_mem_req,
    output logic host_mem_grant,
    output logic asleep_pin
);
    import pdt_pkg::*;

    typedef enum logic [1:0] {
        ST_AWAKE,
        ST_COUNT,
        ST_SETTLE,
        ST_HOLD
    } pdt_state_t;

    typedef struct packed {
        pdt_state_t state;
        logic [22:0] length;
        logic stay;
        logic [22:0] down;
        logic [7:0] settle;
        logic [3:0] settle_time;
        logic [23:0] ticks;
        logic permit;
        logic [1:0] fwait;
        logic busy;
        logic done;
        logic [2:0] wclk;
        logic [1:0] wstates;
        logic fwaiting;
        logic fready;
        logic grant;
        logic [7:0] rdata;
    } pdt_regs_t;

    pdt_regs_t q;
    pdt_regs_t d;

    function automatic logic [7:0] read_mux(input pdt_regs_t r,
                                            input logic [3:0] a);
        case (a)
            PDT_SLEEP_LENGTH_LOW: read_mux = r.length[7:0];
            PDT_SLEEP_LENGTH_MID: read_mux = r.length[15:8];
            PDT_SLEEP_LENGTH_HIGH_HOLD: read_mux = {r.stay, r.length[22:16]};
            PDT_TICK_COUNT_LOW: read_mux = r.ticks[7:0];
            PDT_TICK_COUNT_MID: read_mux = r.ticks[15:8];
            PDT_TICK_COUNT_HIGH: read_mux = r.ticks[23:16];
            // Reserved bits read as zero here.
            PDT_FLASH_TIMING: read_mux = {4'h0, r.permit, 1'b0, r.fwait};
            PDT_WAKE_SETTLE: read_mux = {r.settle_time, 4'h0};
            default: read_mux = 8'h00;
        endcase
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.rdata = read_mux(q, bus.addr);
        if (bus.wr_en) begin
            case (bus.addr)
                PDT_SLEEP_LENGTH_LOW: d.length[7:0] = bus.wdata;
                PDT_SLEEP_LENGTH_MID: d.length[15:8] = bus.wdata;
                PDT_SLEEP_LENGTH_HIGH_HOLD: begin
                    d.length[22:16] = bus.wdata[6:0];
                    d.stay = bus.wdata[PDT_STAY_ASLEEP_BIT];
                end
                PDT_FLASH_TIMING: begin
                    d.permit = bus.wdata[PDT_HOST_PERMIT_BIT];
                    d.fwait = bus.wdata[1:0];
                end
                PDT_WAKE_SETTLE:
                    d.settle_time = bus.wdata[PDT_SETTLE_LSB +: 4];
                // Tick count writes are dropped so the count stays intact.
                default: ;
            endcase
        end
        if (bus.slow_tick) begin
            d.ticks = q.ticks + 24'h000001;
        end
        case (q.state)
            ST_AWAKE: begin
                if (bus.sleep_command) begin
                    d.busy = 1'b1;
                    d.down = q.length;
                    d.state = q.stay ? ST_HOLD : ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (q.down == 23'h000000) begin
                    d.settle = 8'(q.settle_time *
                                  PDT_SETTLE_TICKS_PER_UNIT);
                    d.state = ST_SETTLE;
                end else if (bus.slow_tick) begin
                    d.down = q.down - 23'h000001;
                end
            end
            ST_SETTLE: begin
                if (q.settle == 8'h00) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    d.state = ST_AWAKE;
                end else if (bus.slow_tick) begin
                    d.settle = q.settle - 8'h01;
                end
            end
            ST_HOLD: begin
                if (!bus.card_sleep_bit || bus.cancel_sleep_bit) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    d.state = ST_AWAKE;
                end
            end
            default: d.state = ST_AWAKE;
        endcase
        // Flash wait: each state is two main clocks.
        d.fready = 1'b0;
        if (flash_req && !q.fwaiting && !q.fready) begin
            if (q.fwait == 2'h0) begin
                d.fready = 1'b1;
            end else begin
                d.fwaiting = 1'b1;
                d.wstates = q.fwait;
                d.wclk = PDT_WAIT_CLOCKS_ONE;
            end
        end else if (q.fwaiting) begin
            if (q.wclk > 3'h1) begin
                d.wclk = q.wclk - 3'h1;
            end else if (q.wstates > 2'h1) begin
                d.wstates = q.wstates - 2'h1;
                d.wclk = PDT_WAIT_CLOCKS_ONE;
            end else begin
                d.fwaiting = 1'b0;
                d.fready = 1'b1;
            end
        end
        d.grant = host_mem_req && q.permit;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.state <= ST_AWAKE;
            q.length <= {PDT_LENGTH_RESET[6:0], PDT_LENGTH_RESET,
                         PDT_LENGTH_RESET};
            q.ticks <= PDT_TICK_RESET;
            q.permit <= PDT_HOST_PERMIT_RESET;
            q.fwait <= PDT_FLASH_WAIT_RESET;
            q.settle_time <= PDT_SETTLE_RESET;
        end else begin
            q <= d;
        end
    end

    assign bus.rdata = q.rdata;
    assign bus.sleep_done_flag = q.done;
    assign bus.sleep_irq = q.done;
    assign bus.asleep = q.busy;
    assign bus.host_memory_permit = q.permit;
    assign bus.flash_wait_count = q.fwait;
    assign flash_ready = q.fready;
    assign host_mem_grant = q.grant;
    assign asleep_pin = q.busy;
endmodule

// ===== logic/pdt_pkg.sv
package pdt_pkg;
    // ****************************************************************
    // Register indices on the embedded controller register port
    // ****************************************************************
    localparam logic [3:0] PDT_SLEEP_LENGTH_LOW = 4'h2;
    localparam logic [3:0] PDT_SLEEP_LENGTH_MID = 4'h3;
    localparam logic [3:0] PDT_SLEEP_LENGTH_HIGH_HOLD = 4'h4;
    localparam logic [3:0] PDT_TICK_COUNT_LOW = 4'h5;
    localparam logic [3:0] PDT_TICK_COUNT_MID = 4'h6;
    localparam logic [3:0] PDT_TICK_COUNT_HIGH = 4'h7;
    localparam logic [3:0] PDT_FLASH_TIMING = 4'h8;
    localparam logic [3:0] PDT_WAKE_SETTLE = 4'h1;
    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int PDT_STAY_ASLEEP_BIT = 7;
    localparam int PDT_HOST_PERMIT_BIT = 3;
    localparam int PDT_SETTLE_LSB = 4;
    localparam logic [7:0] PDT_LENGTH_RESET = 8'h00;
    localparam logic [23:0] PDT_TICK_RESET = 24'h000000;
    localparam logic PDT_HOST_PERMIT_RESET = 1'b1;
    localparam logic [1:0] PDT_FLASH_WAIT_RESET = 2'h3;
    localparam logic [3:0] PDT_SETTLE_RESET = 4'h0;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int PDT_SETTLE_TICKS_PER_UNIT = 16;
    localparam int PDT_CLOCKS_PER_WAIT_STATE = 2;
    localparam logic [2:0] PDT_WAIT_CLOCKS_ONE = 3'(PDT_CLOCKS_PER_WAIT_STATE);
    localparam int PDT_MCLK_PERIOD_NS = 50;
endpackage

// ===== logic/pdt_if.sv
`timescale 1ns/1ps
interface pdt_if;
    // Register port driven by the controller end; rdata comes from the device end.
    logic wr_en;
    logic rd_en;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    // Power state controls from the controller end.
    logic sleep_command;
    logic card_sleep_bit;
    logic cancel_sleep_bit;
    // Status from the device end, plus the slow tick from the controller end.
    logic sleep_done_flag;
    logic sleep_irq;
    logic asleep;
    logic host_memory_permit;
    logic [1:0] flash_wait_count;
    logic slow_tick;
    modport device (
        input wr_en, rd_en, addr, wdata, sleep_command, card_sleep_bit,
        input cancel_sleep_bit, slow_tick,
        output rdata, sleep_done_flag, sleep_irq, asleep,
        output host_memory_permit, flash_wait_count
    );
    modport ctrl (
        output wr_en, rd_en, addr, wdata, sleep_command, card_sleep_bit,
        output cancel_sleep_bit, slow_tick,
        input rdata, sleep_done_flag, sleep_irq, asleep,
        input host_memory_permit, flash_wait_count
    );
endinterface

// ===== logic/pdt_ctrl.sv
`timescale 1ns/1ps
module pdt_ctrl (
    input wire logic mclk,
    input wire logic resetn,
    pdt_if.ctrl bus,
    input wire logic req_write,
    input wire logic req_read,
    input wire logic [3:0] req_addr,
    input wire logic [7:0] req_data,
    input wire logic req_sleep,
    input wire logic req_card_sleep,
    input wire logic req_cancel,
    input wire logic req_tick,
    output logic [7:0] rd_data,
    output logic sleep_done,
    output logic asleep
);
    import pdt_pkg::*;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
        logic cmd;
        logic card;
        logic cancel;
        logic tick;
        logic [7:0] rdata;
        logic done;
        logic asleep;
    } pdt_ctrl_regs_t;

    pdt_ctrl_regs_t q;
    pdt_ctrl_regs_t d;

    // ****************************************************************
    // Request staging
    // ****************************************************************
    always_comb begin
        d = q;
        // Tick count is read-only; such writes are not issued.
        d.wr = req_write && !(req_addr >= PDT_TICK_COUNT_LOW &&
                              req_addr <= PDT_TICK_COUNT_HIGH);
        d.rd = req_read;
        d.addr = req_addr;
        // Reserved flash bits are forced to zero.
        d.wdata = (req_addr == PDT_FLASH_TIMING) ? (req_data & 8'h0B)
                                                 : req_data;
        // The length is expected loaded before the command.
        d.cmd = req_sleep;
        d.card = req_card_sleep;
        d.cancel = req_cancel;
        d.tick = req_tick;
        d.rdata = bus.rdata;
        d.done = bus.sleep_done_flag;
        d.asleep = bus.asleep;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.wr_en = q.wr;
    assign bus.rd_en = q.rd;
    assign bus.addr = q.addr;
    assign bus.wdata = q.wdata;
    assign bus.sleep_command = q.cmd;
    assign bus.card_sleep_bit = q.card;
    assign bus.cancel_sleep_bit = q.cancel;
    assign bus.slow_tick = q.tick;
    assign rd_data = q.rdata;
    assign sleep_done = q.done;
    assign asleep = q.asleep;
endmodule

// ===== verif/pdt_asserts.sv
`timescale 1ns/1ps
// ****************************************
// Interface checker
// ****************************************
module pdt_asserts
    import pdt_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic sleep_command,
    input wire logic cancel_sleep_bit,
    input wire logic sleep_done_flag,
    input wire logic sleep_irq,
    input wire logic asleep,
    input wire logic host_memory_permit,
    input wire logic [1:0] flash_wait_count
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    wire logic fw = wr_en && addr == PDT_FLASH_TIMING;
    a_done_single: assert property (sleep_done_flag |=> !sleep_done_flag)
        else $error("done flag longer than one cycle");
    a_irq_with_done: assert property (sleep_irq == sleep_done_flag)
        else $error("interrupt differs from done flag");
    a_done_wakes: assert property (sleep_done_flag |-> ##[0:1] !asleep)
        else $error("still asleep after done");
    a_cmd_sleeps: assert property (sleep_command && !asleep |=> asleep)
        else $error("command did not start sleep");
    a_cancel_wakes: assert property (asleep && cancel_sleep_bit
        |-> ##[1:2] sleep_done_flag) else $error("cancel did not wake");
    a_wait_written: assert property (fw
        |=> flash_wait_count == $past(wdata[1:0])) else $error("wait code");
    a_permit_written: assert property (fw
        |=> host_memory_permit == $past(wdata[3])) else $error("permit bit");
    a_flash_held: assert property (!fw |=> $stable(flash_wait_count))
        else $error("wait code changed without write");
    a_reserved_zero: assert property (addr == PDT_FLASH_TIMING
        |=> rdata[7:4] == 4'h0 && !rdata[2]) else $error("reserved bits");
    cover property (sleep_done_flag);
    cover property (asleep && cancel_sleep_bit);
    cover property (fw && wdata[1:0] == 2'h0);
endmodule

// ===== verif/pdt_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module pdt_tb_top;
    import pdt_pkg::*;
    logic mclk = 1'b0, resetn = 1'b0, rq_w = 1'b0, rq_s = 1'b0, rq_c = 1'b0;
    logic rq_x = 1'b0, rq_t = 1'b0, f_rq = 1'b0, h_rq = 1'b0, f_rdy, h_gnt;
    logic [3:0] rq_a = 4'h0;
    logic [7:0] rq_d = 8'h00, rd_data;
    logic sleep_done, asleep, a_pin;
    int n_fail = 0, tests_run = 0, n_done = 0;
    pdt_if b();
    pdt_device pdt_device_inst(.mclk(mclk), .resetn(resetn), .bus(b),
        .flash_req(f_rq), .flash_ready(f_rdy), .host_mem_req(h_rq),
        .host_mem_grant(h_gnt), .asleep_pin(a_pin));
    pdt_ctrl pdt_ctrl_inst(.mclk(mclk), .resetn(resetn), .bus(b),
        .req_write(rq_w), .req_read(1'b0), .req_addr(rq_a), .req_data(rq_d),
        .req_sleep(rq_s), .req_card_sleep(rq_c), .req_cancel(rq_x),
        .req_tick(rq_t), .rd_data(rd_data), .sleep_done(sleep_done),
        .asleep(asleep));
    pdt_asserts pdt_asserts_inst(.mclk(mclk), .resetn(resetn),
        .wr_en(b.wr_en), .addr(b.addr), .wdata(b.wdata), .rdata(b.rdata),
        .sleep_command(b.sleep_command), .cancel_sleep_bit(b.cancel_sleep_bit),
        .sleep_done_flag(b.sleep_done_flag), .sleep_irq(b.sleep_irq),
        .asleep(b.asleep), .host_memory_permit(b.host_memory_permit),
        .flash_wait_count(b.flash_wait_count));
    initial forever #(PDT_MCLK_PERIOD_NS / 2) mclk = ~mclk;
    // Sampled mid-cycle so the one-cycle done pulse is seen settled.
    always @(negedge mclk) if (sleep_done === 1'b1) n_done++;
    // ****************************************
    // Scenario tasks
    // ****************************************
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        rq_w = 1'b1;
        rq_a = a;
        rq_d = d;
        step(1);
        rq_w = 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        rq_a = a;
        step(4);
        `CHK("reg read", e, rd_data)
    endtask
    // A tick is spaced wide enough for a done pulse to reach the bench.
    task automatic tick(input int n);
        repeat (n) begin
            rq_t = 1'b1;
            step(1);
            rq_t = 1'b0;
            step(5);
        end
    endtask
    task automatic go_sleep();
        rq_s = 1'b1;
        step(1);
        rq_s = 1'b0;
        step(3);
    endtask
    task automatic t_regs();
        for (int a = 2; a < 8; a++) rd(4'(a), 8'h00);
        rd(PDT_FLASH_TIMING, 8'h0B);
        rd(PDT_WAKE_SETTLE, 8'h00);
        wr(PDT_SLEEP_LENGTH_MID, 8'h5A);
        rd(PDT_SLEEP_LENGTH_MID, 8'h5A);
        wr(PDT_SLEEP_LENGTH_HIGH_HOLD, 8'h7F);
        rd(PDT_SLEEP_LENGTH_HIGH_HOLD, 8'h7F);
        wr(PDT_TICK_COUNT_LOW, 8'hFF);
        rd(PDT_TICK_COUNT_LOW, 8'h00);
    endtask
    task automatic t_sleep();
        int n0, k, e;
        e = 3 + PDT_SETTLE_TICKS_PER_UNIT;
        tick(261);
        rd(PDT_TICK_COUNT_LOW, 8'h05);
        rd(PDT_TICK_COUNT_MID, 8'h01);
        wr(PDT_SLEEP_LENGTH_LOW, 8'h03);
        wr(PDT_SLEEP_LENGTH_MID, 8'h00);
        wr(PDT_SLEEP_LENGTH_HIGH_HOLD, 8'h00);
        wr(PDT_WAKE_SETTLE, 8'h10);
        n0 = n_done;
        go_sleep();
        `CHK("asleep", 1'b1, asleep)
        `CHK("asleep pin", 1'b1, a_pin)
        for (k = 0; k < 40 && n_done == n0; k++) tick(1);
        `CHK("sleep ticks", e, k)
        `CHK("pin awake", 1'b0, a_pin)
        rd(PDT_TICK_COUNT_LOW, 8'h18);
    endtask
    task automatic t_stay();
        int n0;
        wr(PDT_SLEEP_LENGTH_HIGH_HOLD, 8'h80);
        for (int m = 0; m < 2; m++) begin
            rq_c = 1'b1;
            n0 = n_done;
            go_sleep();
            tick(30);
            `CHK("stay asleep", 1'b1, asleep)
            if (m == 0) rq_c = 1'b0;
            else rq_x = 1'b1;
            step(1);
            rq_x = 1'b0;
            step(5);
            `CHK("stay wake", n0 + 1, n_done)
        end
        rq_c = 1'b0;
    endtask
    task automatic t_flash();
        int n, e;
        for (int c = 0; c < 4; c++) begin
            e = PDT_CLOCKS_PER_WAIT_STATE * c + 1;
            wr(PDT_FLASH_TIMING, 8'h08 | 8'(c));
            step(3);
            f_rq = 1'b1;
            n = 0;
            do begin
                step(1);
                n++;
            end while (f_rdy !== 1'b1 && n < 20);
            f_rq = 1'b0;
            `CHK("flash wait", e, n)
            if (n >= 20) complete_run();
            step(2);
        end
        h_rq = 1'b1;
        wr(PDT_FLASH_TIMING, 8'h03);
        step(3);
        `CHK("grant blocked", 1'b0, h_gnt)
        wr(PDT_FLASH_TIMING, 8'h08);
        step(3);
        `CHK("grant", 1'b1, h_gnt)
        h_rq = 1'b0;
    endtask
    task automatic complete_run();
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #500000;
        n_fail++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge mclk);
        #2 resetn = 1'b1;
        step(1);
        t_regs();
        t_sleep();
        t_stay();
        t_flash();
        complete_run();
    end
endmodule
